// >>> core/sram_ctl_pkg.sv
/*
 * Shared constants and carrier types for the burst memory control core.
 * Assumes one 25 MHz clock and a synchronous active-high reset.
 */
package sram_ctl_pkg;

  // Wishbone register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;

  // Control register fields and reset value
  localparam int CTRL_ORDER_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register fields
  localparam int STAT_AWAKE_BIT = 0;
  localparam int STAT_BURST_BIT = 1;
  localparam int STAT_BEAT_LSB = 2;
  localparam int STAT_DRIVE_BIT = 4;
  localparam int STAT_OUTVLD_BIT = 5;

  // Burst and power timing
  localparam int BEATS = 4;
  localparam int WAKE_CYCLES = 2;
  localparam logic [1:0] BEAT_FIRST = 2'h0;
  localparam logic [1:0] BEAT_STEP = 2'h1;

  // Pin data layout defaults
  localparam int DATA_W_DEF = 36;
  localparam int ADDR_W_DEF = 17;
  localparam int LANES_DEF = 4;
  localparam int MAX_LANES = 4;
  localparam int BUF_DEPTH = 2;

  // One array access decided at a clock edge
  typedef struct packed {
    logic rd;
    logic wr;
    logic [MAX_LANES-1:0] lanes;
  } access_t;

  // Position inside a four-beat burst
  typedef struct packed {
    logic [1:0] base;
    logic [1:0] beat;
  } burst_pos_t;

endpackage : sram_ctl_pkg

// >>> core/read_word_fifo.sv
/*
 * Small valid/ready FIFO holding read words between the array and the
 * data-out register. Assumes both sides run on clk_i.
 */
`timescale 1ns/1ps
module read_word_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("read_word_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // Full and empty come from the count, so they are never optimistic
  always_comb
  begin
    in_ready_o = (cnt_r != (PW+1)'(DEPTH));
    out_valid_o = (cnt_r != '0);
    out_data_o = mem[rd_r];
    push = in_valid_i & in_ready_o;
    pop = out_valid_o & out_ready_i;
    wr_nxt = push ? PW'(wr_r + 1'b1) : wr_r;
    rd_nxt = pop ? PW'(rd_r + 1'b1) : rd_r;
    cnt_nxt = cnt_r;
    if (push && !pop)
    begin
      cnt_nxt = (PW+1)'(cnt_r + 1'b1);
    end
    else if (pop && !push)
    begin
      cnt_nxt = (PW+1)'(cnt_r - 1'b1);
    end
  end

  // Pointer and count registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; the count hides stale words
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_r] <= in_data_i;
    end
  end

endmodule : read_word_fifo

// >>> core/sync_burst_sram_control.sv
/*
 * Control core of a synchronous pipelined burst memory: strobe and select
 * decode, four-beat burst counter, byte-lane writes, pipelined read path,
 * sleep and output gating, plus a Wishbone register slave.
 * Assumes the burst bus is driven from logic on clk_i; only the output
 * enable pin is asynchronous and is synchronised here.
 */
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
// Operation
// - Order select high: burst low bits are start XOR beat 0,1,2,3.
// - Order select low: burst low bits count up modulo four from start.
// - Sleep floats all data pins whatever the output enable; state held.
// - Awake reads drive data only while output enable is low.
// - Deselect floats data pins and idles while still clocked.
// - Processor strobe with all selects active starts a read; primary select active, another inactive: deselect.
// - Controller strobe, all selects: start write or read by internal write.
// - No strobe taken, advance low, no write: read next burst address.
// - No strobe taken, advance low, write: write next burst address.
// - No strobe taken, advance high, no write: reread current address.
// - No strobe taken, advance high, write: write current address again.
// - Internal write: global write low, or gate low with any lane low.
// - Global write writes all lanes; gated writes only low-enabled lanes.
// - After sleep ends, two cycles of wake-up before operation resumes.
// - Read data captured on one edge, reaches output on the next edge.
// - Burst counter wraps to its start after four beats.
// - Processor-strobe start is a read; write enables and advance ignored.
module sync_burst_sram_control #(
  parameter int DATA_W = sram_ctl_pkg::DATA_W_DEF,
  parameter int ADDR_W = sram_ctl_pkg::ADDR_W_DEF,
  parameter int LANES = sram_ctl_pkg::LANES_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic select_primary_n_i,
  input wire logic select_high_active_i,
  input wire logic select_low_active_n_i,
  input wire logic proc_addr_strobe_n_i,
  input wire logic ctrl_addr_strobe_n_i,
  input wire logic burst_advance_n_i,
  input wire logic global_write_n_i,
  input wire logic byte_write_gate_n_i,
  input wire logic [LANES-1:0] lane_write_n_i,
  input wire logic output_enable_n_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_n_o
);
  localparam int LANE_W = DATA_W / LANES;
  localparam int ML = sram_ctl_pkg::MAX_LANES;

  if (LANES < 1 || LANES > ML || DATA_W % LANES != 0 || ADDR_W < 3)
  begin : g_bad_param
    $error("sync_burst_sram_control: unsupported width parameters");
  end

  typedef enum logic [1:0] {PW_RUN, PW_SLEEP, PW_WAKE} pwr_t;
  typedef enum logic {BS_IDLE, BS_ACTIVE} bst_t;

  // Low address bits of the current beat, either burst order
  function automatic logic [1:0] burst_low(
    input sram_ctl_pkg::burst_pos_t pos,
    input logic interleave
  );
    if (interleave)
    begin
      return pos.base ^ pos.beat;
    end
    return 2'(pos.base + pos.beat);
  endfunction : burst_low

  // Lanes written by one sampled set of write enables
  function automatic logic [ML-1:0] lane_mask(
    input logic gw_n,
    input logic bw_n,
    input logic [LANES-1:0] we_n
  );
    logic [ML-1:0] m;
    m = '0;
    for (int i = 0; i < LANES; i++)
    begin
      m[i] = ~gw_n | (~bw_n & ~we_n[i]);
    end
    return m;
  endfunction : lane_mask

  logic [DATA_W-1:0] mem [2**ADDR_W];

  logic [1:0] ctrl_r, ctrl_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  pwr_t pwr_r, pwr_nxt;
  logic [1:0] wake_r, wake_nxt;
  bst_t bst_r, bst_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  sram_ctl_pkg::burst_pos_t pos_r, pos_nxt;
  sram_ctl_pkg::access_t acc_r, acc_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic oe_meta_r, oe_sync_r;
  logic [DATA_W-1:0] dq_r, dq_nxt;
  logic dq_oe_n_r, dq_oe_n_nxt;
  logic out_vld_r, out_vld_nxt;

  logic sleep, order, wb_hit, take_ok, sel_ok, iwrite;
  logic [ML-1:0] lanes;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] merged;
  logic fifo_in_rdy, fifo_vld, pop;
  logic [DATA_W-1:0] fifo_data;

  assign sleep = ctrl_r[sram_ctl_pkg::CTRL_SLEEP_BIT];
  assign order = ctrl_r[sram_ctl_pkg::CTRL_ORDER_BIT];

  // Wishbone slave: one wait state, ack dropped the cycle after it
  always_comb
  begin
    wb_hit = wb_cyc_i & wb_stb_i & ~ack_r;
    ack_nxt = wb_hit;
    ctrl_nxt = ctrl_r;
    rdat_nxt = '0;
    if (wb_hit && wb_we_i && wb_sel_i[0]
        && wb_adr_i == sram_ctl_pkg::REG_CTRL)
    begin
      ctrl_nxt = wb_dat_i[1:0];
    end
    if (wb_hit && !wb_we_i)
    begin
      // Unmapped offsets still ack and read as zero
      if (wb_adr_i == sram_ctl_pkg::REG_CTRL)
      begin
        rdat_nxt[1:0] = ctrl_r;
      end
      else if (wb_adr_i == sram_ctl_pkg::REG_STATUS)
      begin
        rdat_nxt[sram_ctl_pkg::STAT_AWAKE_BIT] = (pwr_r == PW_RUN);
        rdat_nxt[sram_ctl_pkg::STAT_BURST_BIT] = (bst_r == BS_ACTIVE);
        rdat_nxt[sram_ctl_pkg::STAT_BEAT_LSB +: 2] = pos_r.beat;
        rdat_nxt[sram_ctl_pkg::STAT_DRIVE_BIT] = ~dq_oe_n_r;
        rdat_nxt[sram_ctl_pkg::STAT_OUTVLD_BIT] = out_vld_r;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= sram_ctl_pkg::CTRL_RESET;
      ack_r <= 1'b0;
      rdat_r <= '0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // Power state: sleep blocks commands, leaving it costs a wake delay
  always_comb
  begin
    pwr_nxt = pwr_r;
    wake_nxt = wake_r;
    unique case (pwr_r)
      PW_RUN:
      begin
        if (sleep)
        begin
          pwr_nxt = PW_SLEEP;
        end
      end
      PW_SLEEP:
      begin
        if (!sleep)
        begin
          pwr_nxt = PW_WAKE;
          wake_nxt = 2'(sram_ctl_pkg::WAKE_CYCLES - 1);
        end
      end
      PW_WAKE:
      begin
        if (sleep)
        begin
          pwr_nxt = PW_SLEEP;
        end
        else if (wake_r == 2'h0)
        begin
          pwr_nxt = PW_RUN;
        end
        else
        begin
          wake_nxt = 2'(wake_r - 2'h1);
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwr_r <= PW_RUN;
      wake_r <= 2'h0;
    end
    else
    begin
      pwr_r <= pwr_nxt;
      wake_r <= wake_nxt;
    end
  end

  // Command decode; a full read buffer stalls acceptance
  always_comb
  begin
    take_ok = (pwr_r == PW_RUN) & ~sleep & fifo_in_rdy;
    sel_ok = ~select_primary_n_i & select_high_active_i
             & ~select_low_active_n_i;
    lanes = lane_mask(global_write_n_i, byte_write_gate_n_i,
                      lane_write_n_i);
    iwrite = |lanes;
    bst_nxt = bst_r;
    addr_nxt = addr_r;
    pos_nxt = pos_r;
    acc_nxt = '0;
    wdata_nxt = wdata_r;
    if (!take_ok)
    begin
      acc_nxt = '0;
    end
    else if (!proc_addr_strobe_n_i && !select_primary_n_i)
    begin
      // Enables, advance and the other strobe are ignored here
      bst_nxt = sel_ok ? BS_ACTIVE : BS_IDLE;
      if (sel_ok)
      begin
        addr_nxt = addr_i;
        pos_nxt.base = addr_i[1:0];
        pos_nxt.beat = sram_ctl_pkg::BEAT_FIRST;
        acc_nxt.rd = 1'b1;
      end
    end
    else if (!ctrl_addr_strobe_n_i)
    begin
      bst_nxt = sel_ok ? BS_ACTIVE : BS_IDLE;
      if (sel_ok)
      begin
        addr_nxt = addr_i;
        pos_nxt.base = addr_i[1:0];
        pos_nxt.beat = sram_ctl_pkg::BEAT_FIRST;
        acc_nxt.rd = ~iwrite;
        acc_nxt.wr = iwrite;
        acc_nxt.lanes = lanes;
        wdata_nxt = iwrite ? dq_i : wdata_r;
      end
    end
    else if (bst_r == BS_ACTIVE)
    begin
      if (!burst_advance_n_i)
      begin
        // Two-bit beat wraps by itself after the fourth beat
        pos_nxt.beat = 2'(pos_r.beat + sram_ctl_pkg::BEAT_STEP);
      end
      acc_nxt.rd = ~iwrite;
      acc_nxt.wr = iwrite;
      acc_nxt.lanes = lanes;
      wdata_nxt = iwrite ? dq_i : wdata_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bst_r <= BS_IDLE;
      addr_r <= '0;
      pos_r <= '0;
      acc_r <= '0;
      wdata_r <= '0;
    end
    else
    begin
      bst_r <= bst_nxt;
      addr_r <= addr_nxt;
      pos_r <= pos_nxt;
      acc_r <= acc_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // Array address and lane merge for the access decided last edge
  always_comb
  begin
    acc_addr = {addr_r[ADDR_W-1:2], burst_low(pos_r, order)};
    merged = mem[acc_addr];
    for (int i = 0; i < LANES; i++)
    begin
      if (acc_r.lanes[i])
      begin
        merged[i*LANE_W +: LANE_W] = wdata_r[i*LANE_W +: LANE_W];
      end
    end
  end

  // Cell array; written one cycle after the write was sampled
  always_ff @(posedge clk_i)
  begin
    if (acc_r.wr)
    begin
      mem[acc_addr] <= merged;
    end
  end

  // Buffer holds read words until the data-out register dq_r takes them
  read_word_fifo #(
    .W(DATA_W),
    .DEPTH(sram_ctl_pkg::BUF_DEPTH)
  ) u_read_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(acc_r.rd),
    .in_ready_o(fifo_in_rdy),
    .in_data_i(merged),
    .out_valid_o(fifo_vld),
    .out_ready_i(~sleep),
    .out_data_o(fifo_data)
  );

  // Output buffer and pin gating; the enable pin costs two sync cycles
  always_comb
  begin
    pop = fifo_vld & ~sleep;
    dq_nxt = pop ? fifo_data : dq_r;
    out_vld_nxt = pop | (sleep & out_vld_r);
    dq_oe_n_nxt = ~(out_vld_nxt & ~sleep & ~oe_sync_r
                    & ~acc_nxt.wr);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      oe_meta_r <= 1'b1;
      oe_sync_r <= 1'b1;
      dq_r <= '0;
      dq_oe_n_r <= 1'b1;
      out_vld_r <= 1'b0;
    end
    else
    begin
      oe_meta_r <= output_enable_n_i;
      oe_sync_r <= oe_meta_r;
      dq_r <= dq_nxt;
      dq_oe_n_r <= dq_oe_n_nxt;
      out_vld_r <= out_vld_nxt;
    end
  end

  assign dq_o = dq_r;
  assign dq_oe_n_o = dq_oe_n_r;
  assign wb_dat_o = rdat_r;
  assign wb_ack_o = ack_r;

endmodule : sync_burst_sram_control

// >>> tb/sram_ctl_sva.sv
/* Port checker for the burst memory control core.
   Assumes it is bound to the core and sees only its ports. */
`timescale 1ns/1ps
module sram_ctl_sva #(
  parameter int DATA_W = 36
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic select_primary_n_i,
  input wire logic select_high_active_i,
  input wire logic select_low_active_n_i,
  input wire logic proc_addr_strobe_n_i,
  input wire logic ctrl_addr_strobe_n_i,
  input wire logic global_write_n_i,
  input wire logic output_enable_n_i,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic dq_oe_n_o
);
  logic sleep_r;
  logic sleep_nxt;
  logic sel_ok;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Sleep bit mirror, taken at the ack edge of a control write
  always_comb
  begin
    sleep_nxt = sleep_r;
    if (wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i == sram_ctl_pkg::REG_CTRL)
      sleep_nxt = wb_dat_i[sram_ctl_pkg::CTRL_SLEEP_BIT];
  end
  always_ff @(posedge clk_i)
    sleep_r <= rst_i ? 1'b0 : sleep_nxt;
  assign sel_ok = !select_primary_n_i && select_high_active_i
    && !select_low_active_n_i;
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_on_time: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_ack_has_cause: assert property
    (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && dq_oe_n_o && dq_o == '0)
    else $error("outputs active after reset");
  chk_oe_high_float: assert property
    (output_enable_n_i [*4] |=> dq_oe_n_o)
    else $error("data driven with output enable high");
  chk_sleep_float: assert property
    (sleep_r && $past(sleep_r) |-> dq_oe_n_o)
    else $error("data driven in sleep");
  chk_write_float: assert property
    (sel_ok && !ctrl_addr_strobe_n_i
    && proc_addr_strobe_n_i && !global_write_n_i |=> dq_oe_n_o)
    else $error("data driven in a write cycle");
endmodule : sram_ctl_sva

bind sync_burst_sram_control sram_ctl_sva #(.DATA_W(DATA_W)) u_sva (.*);

// >>> tb/burst_master_model.sv
/* Bus master model driving the synchronous burst bus of the core.
   Assumes one clock; one command per rising edge. */
`timescale 1ns/1ps
module burst_master_model (
  input wire logic clk_i,
  output logic [16:0] addr_o,
  output logic sel_primary_n_o,
  output logic sel_high_o,
  output logic sel_low_n_o,
  output logic proc_strobe_n_o,
  output logic ctrl_strobe_n_o,
  output logic advance_n_o,
  output logic [5:0] wr_n_o,
  output logic oe_n_o,
  output logic [35:0] dq_o
);
  // Start deselected with outputs off
  initial
  begin
    addr_o = 17'h00000;
    {sel_primary_n_o, sel_high_o, sel_low_n_o} = 3'h4;
    {proc_strobe_n_o, ctrl_strobe_n_o, advance_n_o} = 3'h7;
    wr_n_o = 6'h3F;
    oe_n_o = 1'b1;
    dq_o = 36'h0;
  end
  // Codes: 0 deselect, 1 proc start, 2 ctrl start, 3 advance,
  // 4 suspend, 5 and 6 proc start with one select inactive
  task automatic op(input logic [2:0] c, input logic [16:0] a,
    input logic [35:0] d, input logic [5:0] w);
    @(posedge clk_i);
    addr_o <= a;
    sel_primary_n_o <= (c == 3'h0);
    sel_high_o <= (c != 3'h5);
    sel_low_n_o <= (c == 3'h6);
    proc_strobe_n_o <= !(c == 3'h1 || c >= 3'h5);
    ctrl_strobe_n_o <= !(c == 3'h2 || c == 3'h0);
    advance_n_o <= (c != 3'h3);
    wr_n_o <= w;
    // Released data toggles so a stale value is never mistaken
    dq_o <= (c != 3'h0 && (!w[5] || (!w[4] && !(&w[3:0])))) ? d : ~dq_o;
  endtask : op
  // Output enable passes two sync flops, so wait before the next use
  task automatic set_oe(input logic v);
    @(posedge clk_i);
    oe_n_o <= v;
    repeat (3) @(posedge clk_i);
  endtask : set_oe
endmodule : burst_master_model

// >>> tb/tb.sv
/* Self-checking bench for the burst memory control core.
   Assumes the core's default widths and the bound port checker. */
`timescale 1ns/1ps
module tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, xs;
  logic [16:0] addr_i;
  logic select_primary_n_i, select_high_active_i, select_low_active_n_i;
  logic proc_addr_strobe_n_i, ctrl_addr_strobe_n_i, burst_advance_n_i;
  logic global_write_n_i, byte_write_gate_n_i, output_enable_n_i;
  logic [3:0] lane_write_n_i;
  logic [35:0] dq_i, dq_o;
  logic dq_oe_n_o;
  logic [35:0] mem [logic [16:0]];
  logic [35:0] rq [$];
  logic [31:0] wq [$];
  int fail_count, n_checks, cycles;

  sync_burst_sram_control u_dut (.*);
  burst_master_model u_bus (.clk_i(clk_i), .addr_o(addr_i),
    .sel_primary_n_o(select_primary_n_i), .sel_high_o(select_high_active_i),
    .sel_low_n_o(select_low_active_n_i), .proc_strobe_n_o(proc_addr_strobe_n_i),
    .ctrl_strobe_n_o(ctrl_addr_strobe_n_i), .advance_n_o(burst_advance_n_i),
    .wr_n_o({global_write_n_i, byte_write_gate_n_i, lane_write_n_i}),
    .oe_n_o(output_enable_n_i), .dq_o(dq_i));

  function automatic logic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction : rnd
  function automatic logic [35:0] rnd36();
    logic [31:0] h;
    h = rnd();
    return {h[3:0], rnd()};
  endfunction : rnd36
  // Burst address: only the two low bits move
  function automatic logic [16:0] baddr(input logic [16:0] a,
    input logic il, input logic [1:0] k);
    return {a[16:2], il ? (a[1:0] ^ k) : (a[1:0] + k)};
  endfunction : baddr
  function automatic logic [35:0] merge(input logic [35:0] o,
    input logic [35:0] n, input logic [5:0] w);
    logic [35:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (!w[5] || (!w[4] && !w[i])) r[9*i +: 9] = n[9*i +: 9];
    return r;
  endfunction : merge

  task automatic cmp(input string nm, input logic [35:0] e,
    input logic [35:0] s);
    n_checks++;
    if (s !== e || $isunknown(e))
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb
  task automatic wburst(input logic [16:0] a, input logic [5:0] w);
    logic [35:0] d;
    for (int k = 0; k < 4; k++)
    begin
      d = rnd36();
      mem[baddr(a, 0, k)] = merge(mem[baddr(a, 0, k)], d, w);
      u_bus.op(k == 0 ? 3'h2 : 3'h3, a, d, w);
    end
  endtask : wburst
  task automatic rburst(input logic [16:0] a, input logic il,
    input logic [2:0] c);
    for (int k = 0; k < 4; k++)
    begin
      rq.push_back(mem[baddr(a, il, k)]);
      u_bus.op(k == 0 ? c : 3'h3, a, 36'h0, 6'h3F);
    end
  endtask : rburst
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      complete_run();
    end
  end
  // Result watcher: each driven word or read ack takes the oldest note
  always @(negedge clk_i)
  begin
    if (dq_oe_n_o === 1'b0)
      cmp("dq_o", rq.size() ? rq.pop_front() : 36'bx, dq_o);
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      cmp("wb_dat_o", wq.size() ? {4'h0, wq.pop_front()} : 'x,
        {4'h0, wb_dat_o});
  end

  initial
  begin
    xs = 32'h0000FEC2;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // Register reset values, unmapped place, write with lane 0 off
    wq = '{32'h0, 32'h1, 32'h0, 32'h0};
    wb(0, sram_ctl_pkg::REG_CTRL, 32'h0, 4'hF);
    wb(0, sram_ctl_pkg::REG_STATUS, 32'h0, 4'hF);
    wb(0, 8'h08, 32'h0, 4'hF);
    wb(1, sram_ctl_pkg::REG_CTRL, 32'h3, 4'h0);
    wb(0, sram_ctl_pkg::REG_CTRL, 32'h0, 4'hF);
    $display("test registers done");
    // Writes: global burst, suspended rewrite, lane write, hidden read
    u_bus.set_oe(1'b1);
    wburst(17'h00040, 6'h1F);
    mem[17'h00043] = rnd36();
    u_bus.op(3'h4, 17'h00040, mem[17'h00043], 6'h1F);
    mem[17'h00041] = merge(mem[17'h00041], rnd36(), 6'h25);
    u_bus.op(3'h2, 17'h00041, mem[17'h00041] ^ 36'h0, 6'h25);
    // With the enable pin high this word must stay off the pins: no note
    u_bus.op(3'h1, 17'h00040, 36'h0, 6'h3F);
    u_bus.op(3'h0, 17'h0, 36'h0, 6'h3F);
    $display("test writes done");
    // Reads: ignored write enables, linear wrap, suspend, deselects
    u_bus.set_oe(1'b0);
    rq.push_back(mem[17'h00040]);
    u_bus.op(3'h1, 17'h00040, rnd36(), 6'h00);
    rburst(17'h00042, 0, 3'h1);
    rq.push_back(mem[17'h00041]);
    u_bus.op(3'h4, 17'h00042, 36'h0, 6'h3F);
    u_bus.op(3'h5, 17'h00040, 36'h0, 6'h3F);
    u_bus.op(3'h6, 17'h00040, 36'h0, 6'h3F);
    wb(1, sram_ctl_pkg::REG_CTRL, 32'h1, 4'hF);
    rburst(17'h00041, 1, 3'h2);
    u_bus.op(3'h0, 17'h0, 36'h0, 6'h3F);
    $display("test reads done");
    // Sleep ignores commands; the bus is parked on deselect before wake
    wb(1, sram_ctl_pkg::REG_CTRL, 32'h2, 4'hF);
    u_bus.op(3'h1, 17'h00040, 36'h0, 6'h3F);
    u_bus.op(3'h0, 17'h0, 36'h0, 6'h3F);
    wb(1, sram_ctl_pkg::REG_CTRL, 32'h0, 4'hF);
    // Sampled on the last wake edge, so it must be dropped
    u_bus.op(3'h1, 17'h00040, 36'h0, 6'h3F);
    rq.push_back(mem[17'h00042]);
    u_bus.op(3'h1, 17'h00042, 36'h0, 6'h3F);
    u_bus.op(3'h0, 17'h0, 36'h0, 6'h3F);
    repeat (8) @(posedge clk_i);
    cmp("pending words", 36'h0, 36'(rq.size()));
    $display("test sleep done");
    complete_run();
  end
endmodule : tb
